// ---- verilog/rsm_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
`default_nettype none
package rsm_pkg;
   // Clock
   localparam int unsigned CLK_HZ = 10_000_000;

   // Register indices (printed offsets are not all multiples of four), shifted left by two into byte addresses
   localparam logic [7:0] IDX_RST_TIMING  = 8'h48;
   localparam logic [7:0] IDX_FORCE_SHDN  = 8'h49;
   localparam logic [7:0] IDX_INPUT_LIMIT = 8'h51;
   localparam logic [7:0] IDX_ADAPTER_CFG = 8'h69;
   localparam logic [7:0] IDX_PWR_STATUS  = 8'h6f;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h71;
   localparam logic [7:0] IDX_CRIT_STATUS = 8'h72;
   localparam logic [11:0] ADDR_RST_TIMING  = {2'h0, IDX_RST_TIMING, 2'h0};
   localparam logic [11:0] ADDR_FORCE_SHDN  = {2'h0, IDX_FORCE_SHDN, 2'h0};
   localparam logic [11:0] ADDR_INPUT_LIMIT = {2'h0, IDX_INPUT_LIMIT, 2'h0};
   localparam logic [11:0] ADDR_ADAPTER_CFG = {2'h0, IDX_ADAPTER_CFG, 2'h0};
   localparam logic [11:0] ADDR_PWR_STATUS  = {2'h0, IDX_PWR_STATUS, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STATUS  = {2'h0, IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] ADDR_IRQ_MASK    = {2'h0, IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] ADDR_CRIT_STATUS = {2'h0, IDX_CRIT_STATUS, 2'h0};

   // Reset values
   localparam logic [7:0] RST_RST_TIMING  = 8'h1c;
   localparam logic [7:0] RST_INPUT_LIMIT = 8'h05;
   localparam logic [7:0] RST_ADAPTER_CFG = 8'h0f;

   // Field positions
   localparam int unsigned POS_RST_DUR    = 3;
   localparam int unsigned POS_CRIT_EN    = 6;
   localparam int unsigned POS_IN_DB      = 4;
   localparam int unsigned POS_AD_DB      = 2;
   localparam int unsigned POS_ADAPT_STAT = 4;

   // Interrupt status bits
   localparam int unsigned IRQ_ADAPT_RISE = 0;
   localparam int unsigned IRQ_ADAPT_FALL = 1;
   localparam int unsigned IRQ_CRIT_LOW   = 2;
   localparam int unsigned IRQ_RESET_DONE = 3;

   // Times in their own units
   localparam int unsigned RTC_TICK_NS  = 30_500;
   localparam int unsigned IN_DB_US     = 10;
   localparam int unsigned AD_DB0_US    = 81;
   localparam int unsigned RST_MS [4]   = '{20, 40, 80, 200};
   localparam int unsigned AD_DB_MS [4] = '{0, 10, 20, 30};
   localparam int unsigned RTC_TICK_CYC = RTC_TICK_NS * (CLK_HZ / 1_000_000)
                                          / 1000;
   localparam int unsigned IN_DB_CYC    = IN_DB_US * (CLK_HZ / 1_000_000);
   localparam int unsigned AD_DB0_CYC   = AD_DB0_US * (CLK_HZ / 1_000_000);
   localparam int unsigned MS_CYC       = CLK_HZ / 1000;

   // Forced-reset sequencer states
   typedef enum logic [2:0] {
      RS_POR  = 3'b001,
      RS_HOLD = 3'b010,
      RS_RUN  = 3'b100
   } rsm_rst_state_t;

   // Sense configuration as one carrier
   typedef struct packed {
      logic       crit_en;
      logic [1:0] in_db_sel;
      logic [3:0] crit_th_sel;
      logic [1:0] ad_db_sel;
      logic [1:0] ad_mode;
   } rsm_cfg_t;
endpackage
`default_nettype wire

// ---- verilog/rsm_debounce.sv ----
// Stable-level debounce filter with restart on reversion
`default_nettype none
module rsm_debounce (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        raw_in,
   input  wire logic [31:0] hold_cyc,
   output logic             level_r
);
   logic [31:0] cnt_r;

   // Count while the candidate differs; zero hold passes straight through
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r   <= 32'h0;
         level_r <= 1'b0;
      end else if (raw_in == level_r) begin
         cnt_r <= 32'h0; // Reverted: restart
      end else if (cnt_r + 32'h1 >= hold_cyc) begin
         level_r <= raw_in; // Stable for whole time
         cnt_r   <= 32'h0;
      end else begin
         cnt_r <= cnt_r + 32'h1;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/rsm_rtc_tick.sv ----
// Slow real-time-clock tick generator
`default_nettype none
module rsm_rtc_tick (
   input  wire logic core_clk,
   input  wire logic rst_n,
   output logic      tick_r
);
   logic [15:0] div_r;

   // One pulse each tick period of core clocks
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_r  <= 16'h0;
         tick_r <= 1'b0;
      end else if (div_r == 16'(rsm_pkg::RTC_TICK_CYC - 1)) begin
         div_r  <= 16'h0;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 16'h1;
         tick_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/rsm_ctrl.sv ----
// Reset timing, forced reset and supply/adapter monitor control over APB
// Summary of operation
// - Reset hold time by 2-bit code: 20, 40, 80, 200 ms; resets to 11.
// - 3-bit reset threshold code drives comparator; resets to 100 (2.4 V).
// - Writing 1 forces emergency reset, bit self clears; 0 does nothing.
// - Input critical comparator enabled only while bit 6 is 1; reset 0.
// - Input sense debounce: none, 10 us, one tick, two ticks.
// - 4-bit critical threshold; 0000 no limit, 1xxx invalid; reset 0101.
// - Adapter debounce: 81 us, 10 ms, 20 ms, 30 ms; reset 11.
// - Slow tick of about 30.5 us times tick-based debounce periods.
// - Debounced adapter state readable at status bit 4.
`default_nettype none
module rsm_ctrl #(
   parameter int unsigned RST_MS_CYC = rsm_pkg::MS_CYC,
   parameter int unsigned AD_MS_CYC  = rsm_pkg::MS_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        input_sense_pin,
   input  wire logic        adapter_present_input,
   output logic             sys_reset_n,
   output logic [2:0]       reset_threshold_sel,
   output logic             input_crit_comparator_en,
   output logic [3:0]       input_crit_threshold_sel,
   output logic             irq
);
   // Software registers
   logic [7:0]             rst_timing_r;
   logic [7:0]             input_limit_r;
   logic [7:0]             adapter_cfg_r;
   logic                   force_emergency_reset_r;
   logic [3:0]             irq_stat_r;
   logic [3:0]             irq_mask_r;

   rsm_pkg::rsm_cfg_t      cfg;
   rsm_pkg::rsm_rst_state_t rst_state_r;
   logic [31:0]            rst_cnt_r;

   logic                   rtc_tick;
   logic [1:0]             tick_cnt_r;
   logic                   in_tick_r;
   logic [31:0]            in_us_cnt_r;
   logic                   in_raw_r;
   logic                   in_level_r;

   logic                   adapter_present_status;
   logic                   ad_prev_r;
   logic                   crit_prev_r;
   logic                   ad_rise;
   logic                   ad_fall;

   logic                   wr_go;
   logic                   rd_go;
   logic [31:0]            ad_hold_cyc;
   logic [3:0]             ev;

   // Access takes effect in access phase; zero wait states
   assign wr_go = psel && penable && pwrite;
   assign rd_go = psel && penable && !pwrite;

   // Register index known to the map
   function automatic logic addr_hit(input logic [11:0] a);
      case (a)
         rsm_pkg::ADDR_RST_TIMING, rsm_pkg::ADDR_FORCE_SHDN,
         rsm_pkg::ADDR_INPUT_LIMIT, rsm_pkg::ADDR_ADAPTER_CFG,
         rsm_pkg::ADDR_PWR_STATUS, rsm_pkg::ADDR_IRQ_STATUS,
         rsm_pkg::ADDR_IRQ_MASK, rsm_pkg::ADDR_CRIT_STATUS: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   endfunction

   // Millisecond figure to clock cycles
   function automatic logic [31:0] ms_cyc(input int unsigned ms,
                                          input int unsigned per_ms);
      ms_cyc = 32'(ms * per_ms);
   endfunction

   // Configuration view of the registers
   always_comb begin
      cfg.crit_en     = input_limit_r[rsm_pkg::POS_CRIT_EN];
      cfg.in_db_sel   = input_limit_r[rsm_pkg::POS_IN_DB +: 2];
      cfg.crit_th_sel = input_limit_r[3:0];
      cfg.ad_db_sel   = adapter_cfg_r[rsm_pkg::POS_AD_DB +: 2];
      cfg.ad_mode     = adapter_cfg_r[1:0];
   end

   // Reset timing register; reserved upper bits stay zero
   // Bits 7:5 are read-only
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_timing_r <= rsm_pkg::RST_RST_TIMING;
      end else if (wr_go && paddr == rsm_pkg::ADDR_RST_TIMING) begin
         rst_timing_r <= {3'h0, pwdata[4:0]};
      end
   end

   // Forced reset bit: write 1 sets, sequencer clears it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         force_emergency_reset_r <= 1'b0;
      end else if (wr_go && paddr == rsm_pkg::ADDR_FORCE_SHDN &&
                   pwdata[0]) begin
         force_emergency_reset_r <= 1'b1;
      end else if (rst_state_r == rsm_pkg::RS_HOLD) begin
         force_emergency_reset_r <= 1'b0; // Self clear
      end
   end

   // Input limit register, all bits writable
   // Bit 7 kept for read-back
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         input_limit_r <= rsm_pkg::RST_INPUT_LIMIT;
      end else if (wr_go && paddr == rsm_pkg::ADDR_INPUT_LIMIT) begin
         input_limit_r <= pwdata[7:0];
      end
   end

   // Adapter configuration register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         adapter_cfg_r <= rsm_pkg::RST_ADAPTER_CFG;
      end else if (wr_go && paddr == rsm_pkg::ADDR_ADAPTER_CFG) begin
         adapter_cfg_r <= pwdata[7:0];
      end
   end

   // Interrupt mask register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_r <= 4'h0;
      end else if (wr_go && paddr == rsm_pkg::ADDR_IRQ_MASK) begin
         irq_mask_r <= pwdata[3:0];
      end
   end

   // Reset sequencer: hold after power-on and after a forced request
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_state_r <= rsm_pkg::RS_POR;
         rst_cnt_r   <= 32'h0;
      end else begin
         case (rst_state_r)
            rsm_pkg::RS_POR: begin
               rst_state_r <= rsm_pkg::RS_HOLD;
               rst_cnt_r   <= 32'h0;
            end
            rsm_pkg::RS_HOLD: begin
               // Duration read live, so a rewrite mid-hold takes effect
               if (rst_cnt_r + 32'h1 >= ms_cyc(
                      rsm_pkg::RST_MS[rst_timing_r[rsm_pkg::POS_RST_DUR +: 2]],
                      RST_MS_CYC)) begin
                  rst_state_r <= rsm_pkg::RS_RUN;
               end else begin
                  rst_cnt_r <= rst_cnt_r + 32'h1;
               end
            end
            rsm_pkg::RS_RUN: begin
               // Full hold after a force
               if (force_emergency_reset_r) begin
                  rst_state_r <= rsm_pkg::RS_HOLD;
                  rst_cnt_r   <= 32'h0;
               end
            end
            default: rst_state_r <= rsm_pkg::RS_POR;
         endcase
      end
   end

   // Reset pin and comparator controls, all registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_n              <= 1'b0;
         // Register defaults
         reset_threshold_sel      <= rsm_pkg::RST_RST_TIMING[2:0];
         input_crit_comparator_en <= 1'b0;
         input_crit_threshold_sel <= rsm_pkg::RST_INPUT_LIMIT[3:0];
      end else begin
         sys_reset_n              <= (rst_state_r == rsm_pkg::RS_RUN) &&
                                     !force_emergency_reset_r;
         reset_threshold_sel      <= rst_timing_r[2:0];
         input_crit_comparator_en <= cfg.crit_en;
         // Invalid 1xxx codes fall back to no limit
         input_crit_threshold_sel <= cfg.crit_th_sel[3] ? 4'h0 :
                                     cfg.crit_th_sel;
      end
   end

   // Slow tick source
   rsm_rtc_tick u_tick (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .tick_r   (rtc_tick)
   );

   // Input sense filter: none, microsecond or tick counted, restart on revert
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         in_raw_r    <= 1'b0;
         in_level_r  <= 1'b0;
         in_us_cnt_r <= 32'h0;
         tick_cnt_r  <= 2'h0;
         in_tick_r   <= 1'b0;
      end else begin
         // Off comparator reads as good
         in_raw_r  <= input_sense_pin && cfg.crit_en;
         in_tick_r <= rtc_tick;
         if (in_raw_r == in_level_r) begin
            in_us_cnt_r <= 32'h0;
            tick_cnt_r  <= 2'h0;
         end else begin
            case (cfg.in_db_sel)
               // No deglitch
               2'h0: in_level_r <= in_raw_r;
               2'h1: begin
                  if (in_us_cnt_r + 32'h1 >= 32'(rsm_pkg::IN_DB_CYC)) begin
                     in_level_r  <= in_raw_r;
                     in_us_cnt_r <= 32'h0;
                  end else begin
                     in_us_cnt_r <= in_us_cnt_r + 32'h1;
                  end
               end
               default: begin
                  // Counted in whole ticks first one may be short
                  if (in_tick_r) begin
                     if (tick_cnt_r + 2'h1 >= {1'b0, cfg.in_db_sel[0]} + 2'h1)
                     begin
                        in_level_r <= in_raw_r;
                        tick_cnt_r <= 2'h0;
                     end else begin
                        tick_cnt_r <= tick_cnt_r + 2'h1;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Adapter hold time selection
   assign ad_hold_cyc = (cfg.ad_db_sel == 2'h0) ?
                        32'(rsm_pkg::AD_DB0_CYC) :
                        ms_cyc(rsm_pkg::AD_DB_MS[cfg.ad_db_sel], AD_MS_CYC);

   // Adapter filter
   rsm_debounce u_ad_db (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .raw_in   (adapter_present_input),
      .hold_cyc (ad_hold_cyc),
      .level_r  (adapter_present_status)
   );

   // Edge detection on filtered levels
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ad_prev_r   <= 1'b0;
         crit_prev_r <= 1'b0;
      end else begin
         ad_prev_r   <= adapter_present_status;
         crit_prev_r <= in_level_r;
      end
   end

   // Edge mode 00 is reserved: no events reported
   assign ad_rise = adapter_present_status && !ad_prev_r &&
                    cfg.ad_mode[0];
   assign ad_fall = !adapter_present_status && ad_prev_r &&
                    cfg.ad_mode[1];

   // One-cycle event pulses
   always_comb begin
      ev = 4'h0;
      ev[rsm_pkg::IRQ_ADAPT_RISE] = ad_rise;
      ev[rsm_pkg::IRQ_ADAPT_FALL] = ad_fall;
      ev[rsm_pkg::IRQ_CRIT_LOW]   = in_level_r && !crit_prev_r;
      ev[rsm_pkg::IRQ_RESET_DONE] = (rst_state_r == rsm_pkg::RS_HOLD) &&
                                    (rst_cnt_r == 32'h0);
   end

   // Sticky status; read clears, but a same-cycle event wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= 4'h0;
      end else if (rd_go && paddr == rsm_pkg::ADDR_IRQ_STATUS) begin
         irq_stat_r <= ev;
      end else begin
         irq_stat_r <= irq_stat_r | ev;
      end
   end

   // Level interrupt from any unmasked sticky bit
   // Registered: no decode glitch on irq
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   // APB read mux and error answer; always zero-wait
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Set in setup, stands in access
         pready  <= psel && !penable;
         // Unmapped: error, zero data
         pslverr <= psel && !penable && !addr_hit(paddr);
         prdata  <= 32'h0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               rsm_pkg::ADDR_RST_TIMING:  prdata <= {24'h0, rst_timing_r};
               rsm_pkg::ADDR_FORCE_SHDN:
                  prdata <= {31'h0, force_emergency_reset_r};
               rsm_pkg::ADDR_INPUT_LIMIT: prdata <= {24'h0, input_limit_r};
               rsm_pkg::ADDR_ADAPTER_CFG: prdata <= {24'h0, adapter_cfg_r};
               rsm_pkg::ADDR_PWR_STATUS:
                  prdata <= {27'h0, adapter_present_status, 4'h0};
               rsm_pkg::ADDR_IRQ_STATUS:  prdata <= {28'h0, irq_stat_r};
               rsm_pkg::ADDR_IRQ_MASK:    prdata <= {28'h0, irq_mask_r};
               rsm_pkg::ADDR_CRIT_STATUS: prdata <= {31'h0, in_level_r};
               default:                   prdata <= 32'h0;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/rsm_cmp_model.sv ----
// Behavioural model of the input-sense and adapter comparators
`default_nettype none
module rsm_cmp_model (
   input  wire logic core_clk,
   input  wire logic sense_lvl,
   input  wire logic adapt_lvl,
   output logic      input_sense_pin,
   output logic      adapter_present_input
);
   timeunit 1ns;
   timeprecision 1ns;
   // Comparator outputs settle one clock after the commanded level moves;
   // high on the adapter line means an adapter is present
   always_ff @(posedge core_clk) begin
      input_sense_pin       <= sense_lvl;
      adapter_present_input <= adapt_lvl;
   end
endmodule
`default_nettype wire

// ---- sim/rsm_ctrl_asserts.sv ----
// Port-level checker for the reset and supply monitor control block
`default_nettype none
module rsm_ctrl_asserts #(
   parameter int unsigned RST_MS_CYC = 10
) (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sys_reset_n,
   input wire logic [2:0]  reset_threshold_sel,
   input wire logic        input_crit_comparator_en,
   input wire logic [3:0]  input_crit_threshold_sel
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int MIN_LOW = 20 * RST_MS_CYC - 2;
   logic        wr_acc;
   logic [7:0]  wd_r;
   logic [31:0] low_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   assign wr_acc = psel && penable && pwrite && pready;
   // Last written byte, so field checks survive the bus moving on
   always_ff @(posedge core_clk) begin
      if (wr_acc) wd_r <= pwdata[7:0];
   end
   // Length of the current low stretch of the system reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) low_r <= 32'h0;
      else if (sys_reset_n) low_r <= 32'h0;
      else low_r <= low_r + 32'h1;
   end
   ready_zero_wait_a: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   slverr_read_zero_a: assert property (pslverr && !pwrite |->
      pready && prdata == 32'h0) else $error("refused read not zero");
   thr_follow_a: assert property (
      wr_acc && paddr == rsm_pkg::ADDR_RST_TIMING
      |=> ##[0:1] reset_threshold_sel == wd_r[2:0])
      else $error("threshold pins do not follow write");
   comp_en_follow_a: assert property (wr_acc &&
      paddr == rsm_pkg::ADDR_INPUT_LIMIT |=> ##[0:1]
      input_crit_comparator_en == wd_r[6])
      else $error("comparator enable does not follow write");
   crit_th_follow_a: assert property (wr_acc &&
      paddr == rsm_pkg::ADDR_INPUT_LIMIT |=> ##[0:1]
      input_crit_threshold_sel == (wd_r[3] ? 4'h0 : wd_r[3:0]))
      else $error("critical threshold does not follow write");
   crit_th_legal_a: assert property (!input_crit_threshold_sel[3])
      else $error("invalid critical threshold driven");
   force_rst_a: assert property (wr_acc && sys_reset_n &&
      pwdata[0] && paddr == rsm_pkg::ADDR_FORCE_SHDN |-> ##2 !sys_reset_n)
      else $error("forced reset not started");
   force_zero_a: assert property (wr_acc && sys_reset_n &&
      !pwdata[0] && paddr == rsm_pkg::ADDR_FORCE_SHDN |-> sys_reset_n[*3])
      else $error("zero write started a reset");
   rst_min_hold_a: assert property ($rose(sys_reset_n) |->
      low_r >= MIN_LOW)
      else $error("system reset released too early");
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// Register-level testbench for the reset and supply monitor control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned MSC = 10;
   logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        sense_lvl, adapt_lvl, input_sense_pin, adapter_present_input;
   logic        sys_reset_n, input_crit_comparator_en, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  reset_threshold_sel;
   logic [3:0]  input_crit_threshold_sel;
   int          n_errors, cmp_count, cyc, t0, t, d;
   logic [11:0] ra [5] = '{rsm_pkg::ADDR_RST_TIMING, rsm_pkg::ADDR_FORCE_SHDN,
      rsm_pkg::ADDR_INPUT_LIMIT, rsm_pkg::ADDR_ADAPTER_CFG,
      rsm_pkg::ADDR_PWR_STATUS};
   logic [7:0]  rv [5] = '{8'h1c, 8'h00, 8'h05, 8'h0f, 8'h00};
   int          slo [4] = '{0, 98, 1, 300};
   int          shi [4] = '{10, 112, 320, 625};
   rsm_ctrl #(.RST_MS_CYC(MSC), .AD_MS_CYC(MSC)) dut (.core_clk(core_clk),
      .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .input_sense_pin(input_sense_pin),
      .adapter_present_input(adapter_present_input),
      .sys_reset_n(sys_reset_n), .reset_threshold_sel(reset_threshold_sel),
      .input_crit_comparator_en(input_crit_comparator_en),
      .input_crit_threshold_sel(input_crit_threshold_sel), .irq(irq));
   rsm_cmp_model u_cmp (.core_clk(core_clk), .sense_lvl(sense_lvl),
      .adapt_lvl(adapt_lvl), .input_sense_pin(input_sense_pin),
      .adapter_present_input(adapter_present_input));
   // 100 ns clock and a free-running cycle count for timing windows
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) cyc <= cyc + 1;
   task complete_run;
      $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task win(input int v, input int lo, input int hi);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask
   // One APB transfer; request held until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] dat);
      int k;
      k = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1 && ++k < 20);
      if (pready !== 1'b1) n_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Read until bit b shows v; t counts cycles since t0
   task poll(input logic [11:0] a, input int b, input logic v);
      do apb(1'b0, a, 32'h0); while (rd[b] !== v && cyc - t0 < 3000);
      t = cyc - t0;
   endtask
   // Adapter move with a filtered-out glitch of half the hold time first
   task adapt_move(input int hold);
      adapt_lvl <= ~adapt_lvl;
      repeat (hold / 2) @(posedge core_clk);
      adapt_lvl <= ~adapt_lvl;
      repeat (hold / 2 + 4) @(posedge core_clk);
      apb(1'b0, rsm_pkg::ADDR_PWR_STATUS, 32'h0);
      chk(32'(rd[4]), 32'(adapt_lvl));
      adapt_lvl <= ~adapt_lvl;
      t0 = cyc;
      poll(rsm_pkg::ADDR_PWR_STATUS, rsm_pkg::POS_ADAPT_STAT, ~adapt_lvl);
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors++;
      complete_run();
   end
   initial begin
      {rst_n, psel, penable, pwrite, sense_lvl, adapt_lvl} = 6'h0;
      {paddr, pwdata, cyc, n_errors, cmp_count} = '0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t0 = cyc;
      @(posedge core_clk);
      chk(32'(reset_threshold_sel), 32'h4);
      chk(32'(input_crit_comparator_en), 32'h0);
      chk(32'(input_crit_threshold_sel), 32'h5);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(rd, 32'(rv[i]));
      end
      apb(1'b0, 12'h004, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      while (sys_reset_n !== 1'b1 && cyc - t0 < 3000) @(posedge core_clk);
      win(cyc - t0, 200 * MSC, 200 * MSC + 12);
      apb(1'b1, rsm_pkg::ADDR_RST_TIMING, 32'hff);
      apb(1'b0, rsm_pkg::ADDR_RST_TIMING, 32'h0);
      chk(rd, 32'h1f);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, rsm_pkg::ADDR_RST_TIMING, 32'(i));
         repeat (2) @(posedge core_clk);
         chk(32'(reset_threshold_sel), 32'(i));
      end
      // Every hold length, each from a forced reset
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, rsm_pkg::ADDR_RST_TIMING, 32'(i << rsm_pkg::POS_RST_DUR));
         apb(1'b1, rsm_pkg::ADDR_FORCE_SHDN, 32'h1);
         t0 = cyc;
         while (sys_reset_n !== 1'b0 && cyc - t0 < 20) @(posedge core_clk);
         while (sys_reset_n !== 1'b1 && cyc - t0 < 3000) @(posedge core_clk);
         win(cyc - t0, rsm_pkg::RST_MS[i] * MSC,
            rsm_pkg::RST_MS[i] * MSC + 8);
         apb(1'b0, rsm_pkg::ADDR_FORCE_SHDN, 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, rsm_pkg::ADDR_FORCE_SHDN, 32'hfe);
      repeat (6) @(posedge core_clk);
      chk(32'(sys_reset_n), 32'h1);
      apb(1'b1, rsm_pkg::ADDR_IRQ_MASK, 32'h0f);
      apb(1'b0, rsm_pkg::ADDR_IRQ_STATUS, 32'h0);
      chk(rd, 32'h8);
      // Every adapter hold time, glitch rejected first
      for (int i = 0; i < 4; i++) begin
         d = (i == 0) ? rsm_pkg::AD_DB0_CYC : rsm_pkg::AD_DB_MS[i] * MSC;
         apb(1'b1, rsm_pkg::ADDR_ADAPTER_CFG, 32'(i << 2 | 3));
         adapt_move(d);
         win(t, d, d + 14);
      end
      // Every edge mode: one rise and one fall, status shows which counted
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, rsm_pkg::ADDR_ADAPTER_CFG, 32'(4 | m));
         apb(1'b0, rsm_pkg::ADDR_IRQ_STATUS, 32'h0);
         adapt_move(10 * MSC);
         adapt_move(10 * MSC);
         repeat (3) @(posedge core_clk);
         chk(32'(irq), 32'(m != 0));
         apb(1'b0, rsm_pkg::ADDR_IRQ_STATUS, 32'h0);
         chk(rd, 32'(m));
         repeat (3) @(posedge core_clk);
         chk(32'(irq), 32'h0);
      end
      // Masked event stays pending and raises irq once unmasked
      apb(1'b1, rsm_pkg::ADDR_IRQ_MASK, 32'h0);
      adapt_move(10 * MSC);
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'h0);
      apb(1'b1, rsm_pkg::ADDR_IRQ_MASK, 32'h01);
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'h1);
      // Disabled comparator hides the sense pin
      sense_lvl <= 1'b1;
      repeat (400) @(posedge core_clk);
      apb(1'b0, rsm_pkg::ADDR_CRIT_STATUS, 32'h0);
      chk(rd, 32'h0);
      sense_lvl <= 1'b0;
      apb(1'b1, rsm_pkg::ADDR_INPUT_LIMIT, 32'h0d);
      repeat (2) @(posedge core_clk);
      chk(32'(input_crit_threshold_sel), 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, rsm_pkg::ADDR_INPUT_LIMIT, 32'h45 | 32'(i << 4));
         repeat (700) @(posedge core_clk);
         chk(32'(input_crit_comparator_en), 32'h1);
         sense_lvl <= 1'b1;
         t0 = cyc;
         poll(rsm_pkg::ADDR_CRIT_STATUS, 0, 1'b1);
         win(t, slo[i], shi[i]);
         sense_lvl <= 1'b0;
      end
      complete_run();
   end
endmodule
bind rsm_ctrl rsm_ctrl_asserts #(.RST_MS_CYC(RST_MS_CYC)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .sys_reset_n(sys_reset_n),
   .reset_threshold_sel(reset_threshold_sel),
   .input_crit_comparator_en(input_crit_comparator_en),
   .input_crit_threshold_sel(input_crit_threshold_sel));
`default_nettype wire
